// File: rtl/lpa_pkg.sv
package lpa_pkg;
    localparam int CLK_NS    = 10;
    localparam int T_HALF_NS = 80;
    localparam int HALF_CYC  = (T_HALF_NS + CLK_NS - 1) / CLK_NS;

    localparam int FRAME_BITS = 32;
    localparam int ADDR_LO    = 25;
    localparam int RW_BIT     = 24;
    localparam int FAULT_BIT  = 23;
    localparam int INT_BIT    = 22;

    localparam logic [6:0] ADDR_LPM_ENTRY = 7'h1c;
    localparam logic [6:0] ADDR_ASEL      = 7'h1d;
    localparam logic [6:0] ADDR_SP_STAT   = 7'h1e;
    localparam logic [6:0] ADDR_SG_STAT   = 7'h1f;

    localparam int         ASEL_CUR_BIT = 6;
    localparam logic [6:0] ASEL_RESET   = 7'h00;
    localparam int         N_GND        = 21;
    localparam int         N_PRG        = 12;
    localparam int         N_CHAN       = 35;
    localparam int         SEL_PRG_LO   = 21;

    localparam logic [7:0] WB_CMD  = 8'h00;
    localparam logic [7:0] WB_RESP = 8'h04;
    localparam logic [7:0] WB_STAT = 8'h08;
    localparam logic [7:0] WB_ISR  = 8'h0c;
    localparam logic [7:0] WB_IMR  = 8'h10;

    localparam logic [31:0] BOOT_CMD = {ADDR_SP_STAT, 1'b0, 24'h000000};

    typedef enum logic [1:0] {
        DEV_NORMAL = 2'b01,
        DEV_LOWP   = 2'b10
    } lpa_dev_e;

    typedef enum logic [4:0] {
        H_IDLE  = 5'b00001,
        H_SETUP = 5'b00010,
        H_LOW   = 5'b00100,
        H_HIGH  = 5'b01000,
        H_HOLD  = 5'b10000
    } lpa_host_e;
endpackage

// File: rtl/lpa_link_if.sv
`timescale 1ns/100ps
`default_nettype none
interface lpa_link_if;
    logic cs_n;
    logic sclk;
    logic mosi;
    logic miso;

    modport dev (
        input  cs_n,
        input  sclk,
        input  mosi,
        output miso
    );

    modport host (
        output cs_n,
        output sclk,
        output mosi,
        input  miso
    );
endinterface
`default_nettype wire

// File: rtl/lpa_dev.sv
`timescale 1ns/100ps
`default_nettype none
module lpa_dev
    import lpa_pkg::*;
(
    input  wire logic              I_CORE_CLK,
    input  wire logic              I_RSTN,
    lpa_link_if.dev                LINK,
    input  wire logic [N_GND-1:0]  I_GND_SW,
    input  wire logic [N_PRG-1:0]  I_PRG_SW,
    input  wire logic              I_FAULT,
    input  wire logic              I_INT_EVENT,
    input  wire logic              I_CFG_POLL_EN,
    input  wire logic              I_CFG_TIMER_EN,
    output logic [N_CHAN-1:0]      O_BUFFERED_ANALOG_OUTPUT_SEL,
    output logic [5:0]             O_BUFFERED_ANALOG_OUTPUT_CHAN,
    output logic                   O_BUFFERED_ANALOG_OUTPUT_WET_PULLUP,
    output logic                   O_LOW_POWER,
    output logic                   O_LP_POLL_EN,
    output logic                   O_LP_TIMER_EN
);
    logic [2:0]       pin_s1;
    logic [2:0]       pin_s2;
    logic [N_GND-1:0] gnd_s1;
    logic [N_GND-1:0] gnd_s2;
    logic [N_PRG-1:0] prg_s1;
    logic [N_PRG-1:0] prg_s2;
    logic             cs_d;
    logic             sck_d;

    // Pins from the host pass two flops before any logic sees them.
    always_ff @(posedge I_CORE_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            pin_s1 <= 3'h4;
            pin_s2 <= 3'h4;
            gnd_s1 <= '0;
            gnd_s2 <= '0;
            prg_s1 <= '0;
            prg_s2 <= '0;
            cs_d   <= 1'b1;
            sck_d  <= 1'b0;
        end else begin
            pin_s1 <= {LINK.cs_n, LINK.sclk, LINK.mosi};
            pin_s2 <= pin_s1;
            gnd_s1 <= I_GND_SW;
            gnd_s2 <= gnd_s1;
            prg_s1 <= I_PRG_SW;
            prg_s2 <= prg_s1;
            cs_d   <= pin_s2[2];
            sck_d  <= pin_s2[1];
        end
    end

    logic cs_n;
    logic sck;
    logic mosi;
    logic cs_fall;
    logic cs_rise;
    logic sck_rise;
    logic sck_fall;

    assign cs_n     = pin_s2[2];
    assign sck      = pin_s2[1];
    assign mosi     = pin_s2[0];
    assign cs_fall  = cs_d & ~cs_n;
    assign cs_rise  = ~cs_d & cs_n;
    assign sck_rise = ~cs_n & sck & ~sck_d;
    assign sck_fall = ~cs_n & ~sck & sck_d;

    lpa_dev_e        state;
    lpa_dev_e        next_state;
    logic [31:0]     shift_in;
    logic [31:0]     next_shift_in;
    logic [31:0]     shift_out;
    logic [31:0]     next_shift_out;
    logic [5:0]      bit_cnt;
    logic [5:0]      next_bit_cnt;
    logic [31:0]     resp;
    logic [31:0]     next_resp;
    logic [6:0]      asel;
    logic [6:0]      next_asel;
    logic [N_CHAN-1:0] sel;
    logic [N_CHAN-1:0] next_sel;
    logic            first_sg;
    logic            next_first_sg;
    logic            int_flg;
    logic            next_int_flg;

    logic [6:0]      cmd_addr;
    logic            cmd_wr;
    logic [23:0]     cmd_data;
    logic            frame_ok;
    logic [21:0]     sg_word;
    logic [21:0]     sp_word;
    logic [31:0]     sg_resp;

    assign cmd_addr = shift_in[FRAME_BITS-1:ADDR_LO];
    assign cmd_wr   = shift_in[RW_BIT];
    assign cmd_data = shift_in[23:0];
    assign frame_ok = cs_rise && (bit_cnt == 6'(FRAME_BITS));

    // The input routed to the analog path reads as open.
    // Mask selected input
    assign sg_word = {1'b0, gnd_s2 & ~sel[N_GND-1:0]};
    assign sp_word = {10'h000, prg_s2 & ~sel[SEL_PRG_LO+N_PRG-1:SEL_PRG_LO]};
    assign sg_resp = {8'h00, I_FAULT, int_flg, sg_word};

    always_comb begin
        next_state     = state;
        next_shift_in  = shift_in;
        next_shift_out = shift_out;
        next_bit_cnt   = bit_cnt;
        next_resp      = resp;
        next_asel      = asel;
        next_first_sg  = first_sg;
        next_int_flg   = int_flg;
        if (cs_fall) begin
            next_shift_out = first_sg ? sg_resp : resp;
            next_bit_cnt   = 6'h00;
            // The live flag leaves in the status word, so it is spent here.
            if (first_sg) begin
                next_int_flg = 1'b0;
            end
            if (state == DEV_LOWP) begin
                next_state = DEV_NORMAL;
            end
        end
        if (sck_rise) begin
            next_shift_in = {shift_in[30:0], mosi};
            if (bit_cnt != 6'h3f) begin
                next_bit_cnt = bit_cnt + 6'h01;
            end
        end
        if (sck_fall) begin
            next_shift_out = {shift_out[30:0], 1'b0};
        end
        if (frame_ok) begin
            next_first_sg = 1'b0;
            next_int_flg  = 1'b0;
            next_resp     = {8'h00, I_FAULT, int_flg, 22'h000000};
            if (cmd_addr == ADDR_ASEL) begin
                next_resp[21:0] = {15'h0000, asel};
                if (cmd_wr) begin
                    next_asel = cmd_data[6:0];
                end
            end else if (cmd_addr == ADDR_SG_STAT) begin
                next_resp[21:0] = sg_word;
            end else if (cmd_addr == ADDR_SP_STAT) begin
                next_resp[21:0] = sp_word;
            end else if (cmd_addr == ADDR_LPM_ENTRY) begin
                if (cmd_wr && cmd_data == 24'h000000) begin
                    next_state    = DEV_LOWP;
                    next_first_sg = 1'b1;
                end
            end
        end
        if (I_INT_EVENT) begin
            next_int_flg = 1'b1;
        end
        for (int k = 0; k < N_CHAN; k++) begin
            next_sel[k] = (next_asel[5:0] == 6'(k + 1));
        end
    end

    // Configuration is never touched by low-power entry or exit.
    // Settings retained
    always_ff @(posedge I_CORE_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            state     <= DEV_NORMAL;
            shift_in  <= 32'h00000000;
            shift_out <= 32'h00000000;
            bit_cnt   <= 6'h00;
            resp      <= 32'h00000000;
            asel      <= ASEL_RESET;
            sel       <= '0;
            first_sg  <= 1'b1;
            int_flg   <= 1'b1;
        end else begin
            state     <= next_state;
            shift_in  <= next_shift_in;
            shift_out <= next_shift_out;
            bit_cnt   <= next_bit_cnt;
            resp      <= next_resp;
            asel      <= next_asel;
            sel       <= next_sel;
            first_sg  <= next_first_sg;
            int_flg   <= next_int_flg;
        end
    end

    assign LINK.miso   = shift_out[FRAME_BITS-1];
    assign O_BUFFERED_ANALOG_OUTPUT_SEL  = sel;
    assign O_BUFFERED_ANALOG_OUTPUT_CHAN = asel[5:0];
    // The only current source offered is a pull-up.
    // Pull-up only
    assign O_BUFFERED_ANALOG_OUTPUT_WET_PULLUP = asel[ASEL_CUR_BIT] & (|sel);
    assign O_LOW_POWER = (state == DEV_LOWP);
    assign O_LP_POLL_EN  = (state == DEV_LOWP) & I_CFG_POLL_EN;
    assign O_LP_TIMER_EN = (state == DEV_LOWP) & I_CFG_TIMER_EN;
endmodule
`default_nettype wire

// File: rtl/lpa_host.sv
`timescale 1ns/100ps
`default_nettype none
module lpa_host
    import lpa_pkg::*;
(
    input  wire logic        I_CORE_CLK,
    input  wire logic        I_RSTN,
    lpa_link_if.host         LINK,
    input  wire logic [7:0]  I_WB_ADR,
    input  wire logic [31:0] I_WB_DAT,
    input  wire logic [3:0]  I_WB_SEL,
    input  wire logic        I_WB_WE,
    input  wire logic        I_WB_CYC,
    input  wire logic        I_WB_STB,
    output logic [31:0]      O_WB_DAT,
    output logic             O_WB_ACK,
    output logic             O_IRQ
);
    logic miso_s1;
    logic miso_s2;

    always_ff @(posedge I_CORE_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            miso_s1 <= 1'b0;
            miso_s2 <= 1'b0;
        end else begin
            miso_s1 <= LINK.miso;
            miso_s2 <= miso_s1;
        end
    end

    lpa_host_e   state;
    lpa_host_e   next_state;
    logic [3:0]  cnt;
    logic [3:0]  next_cnt;
    logic [5:0]  bits;
    logic [5:0]  next_bits;
    logic [31:0] tx;
    logic [31:0] next_tx;
    logic [31:0] rx;
    logic [31:0] next_rx;
    logic [31:0] resp;
    logic [31:0] next_resp;
    logic        boot;
    logic        next_boot;
    logic        isr;
    logic        next_isr;
    logic        imr;
    logic        next_imr;
    logic        ack;
    logic        next_ack;
    logic [31:0] rdat;
    logic [31:0] next_rdat;
    logic        cs_n;
    logic        next_cs_n;
    logic        sclk;
    logic        next_sclk;
    logic        done;
    logic        wb_go;
    logic        half_up;

    assign wb_go   = I_WB_CYC & I_WB_STB & ~ack;
    assign half_up = (cnt == 4'(HALF_CYC - 1));

    always_comb begin
        next_state = state;
        next_cnt   = half_up ? 4'h0 : cnt + 4'h1;
        next_bits  = bits;
        next_tx    = tx;
        next_rx    = rx;
        next_resp  = resp;
        next_boot  = boot;
        next_cs_n  = cs_n;
        next_sclk  = sclk;
        next_ack   = wb_go;
        next_rdat  = rdat;
        next_imr   = imr;
        next_isr   = isr;
        done       = 1'b0;
        case (state)
            H_IDLE: begin
                next_cnt = 4'h0;
                if (boot) begin
                    next_tx    = BOOT_CMD;
                    next_boot  = 1'b0;
                    next_cs_n  = 1'b0;
                    next_state = H_SETUP;
                end else if (wb_go && I_WB_WE && I_WB_ADR == WB_CMD) begin
                    next_tx    = I_WB_DAT;
                    next_cs_n  = 1'b0;
                    next_state = H_SETUP;
                end
            end
            H_SETUP: begin
                next_bits = 6'h00;
                if (half_up) begin
                    next_sclk  = 1'b1;
                    next_rx    = {rx[30:0], miso_s2};
                    next_state = H_HIGH;
                end
            end
            H_HIGH: begin
                if (half_up) begin
                    next_sclk  = 1'b0;
                    next_tx    = {tx[30:0], 1'b0};
                    next_bits  = bits + 6'h01;
                    next_state = (bits == 6'(FRAME_BITS - 1)) ? H_HOLD
                                                               : H_LOW;
                end
            end
            H_LOW: begin
                if (half_up) begin
                    next_sclk  = 1'b1;
                    next_rx    = {rx[30:0], miso_s2};
                    next_state = H_HIGH;
                end
            end
            H_HOLD: begin
                if (half_up) begin
                    next_cs_n  = 1'b1;
                    next_resp  = rx;
                    done       = 1'b1;
                    next_state = H_IDLE;
                end
            end
            default: begin
                next_state = H_IDLE;
            end
        endcase
        if (wb_go) begin
            if (I_WB_ADR == WB_RESP) begin
                next_rdat = resp;
            end else if (I_WB_ADR == WB_STAT) begin
                next_rdat = {31'h00000000, state != H_IDLE};
            end else if (I_WB_ADR == WB_ISR) begin
                next_rdat = {31'h00000000, isr};
            end else if (I_WB_ADR == WB_IMR) begin
                next_rdat = {31'h00000000, imr};
            end else begin
                next_rdat = 32'h00000000;
            end
            if (I_WB_WE && I_WB_SEL[0]) begin
                if (I_WB_ADR == WB_ISR && I_WB_DAT[0]) begin
                    next_isr = 1'b0;
                end else if (I_WB_ADR == WB_IMR) begin
                    next_imr = I_WB_DAT[0];
                end
            end
        end
        // A frame finishing in the clearing cycle keeps its flag.
        if (done) begin
            next_isr = 1'b1;
        end
    end

    always_ff @(posedge I_CORE_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            state <= H_IDLE;
            cnt   <= 4'h0;
            bits  <= 6'h00;
            tx    <= 32'h00000000;
            rx    <= 32'h00000000;
            resp  <= 32'h00000000;
            boot  <= 1'b1;
            isr   <= 1'b0;
            imr   <= 1'b0;
            ack   <= 1'b0;
            rdat  <= 32'h00000000;
            cs_n  <= 1'b1;
            sclk  <= 1'b0;
        end else begin
            state <= next_state;
            cnt   <= next_cnt;
            bits  <= next_bits;
            tx    <= next_tx;
            rx    <= next_rx;
            resp  <= next_resp;
            boot  <= next_boot;
            isr   <= next_isr;
            imr   <= next_imr;
            ack   <= next_ack;
            rdat  <= next_rdat;
            cs_n  <= next_cs_n;
            sclk  <= next_sclk;
        end
    end

    assign LINK.cs_n = cs_n;
    assign LINK.sclk = sclk;
    assign LINK.mosi = tx[FRAME_BITS-1];
    assign O_WB_DAT  = rdat;
    assign O_WB_ACK  = ack;
    assign O_IRQ     = isr & imr;
endmodule
`default_nettype wire

// File: dv/lpa_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module lpa_assertions
    import lpa_pkg::*;
(
    input wire logic              I_CORE_CLK,
    input wire logic              I_RSTN,
    input wire logic              cs_n,
    input wire logic              sclk,
    input wire logic              mosi,
    input wire logic              I_CFG_POLL_EN,
    input wire logic              I_CFG_TIMER_EN,
    input wire logic [N_CHAN-1:0] O_BUFFERED_ANALOG_OUTPUT_SEL,
    input wire logic [5:0]        O_BUFFERED_ANALOG_OUTPUT_CHAN,
    input wire logic              O_BUFFERED_ANALOG_OUTPUT_WET_PULLUP,
    input wire logic              O_LOW_POWER,
    input wire logic              O_LP_POLL_EN,
    input wire logic              O_LP_TIMER_EN
);
    logic [5:0]        rises;
    logic [5:0]        next_rises;
    logic              sclk_q;
    logic [N_CHAN-1:0] exp_sel;

    default clocking cb @(posedge I_CORE_CLK); endclocking
    default disable iff (!I_RSTN);

    // Counts serial clock rises within the current frame.
    always_comb begin
        next_rises = cs_n ? 6'h00 : rises + {5'h00, sclk & ~sclk_q};
        exp_sel = '0;
        if (O_BUFFERED_ANALOG_OUTPUT_CHAN >= 6'h01 && O_BUFFERED_ANALOG_OUTPUT_CHAN <= 6'h23) begin
            exp_sel = 35'h1 << (O_BUFFERED_ANALOG_OUTPUT_CHAN - 6'h01);
        end
    end

    always_ff @(posedge I_CORE_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            rises  <= 6'h00;
            sclk_q <= 1'b0;
        end else begin
            rises  <= next_rises;
            sclk_q <= sclk;
        end
    end

    a_sclk_idle_low: assert property (cs_n |-> !sclk)
        else $error("serial clock high outside a frame");
    a_cs_setup_time: assert property ($fell(cs_n) |-> !sclk [*8])
        else $error("serial clock rose too soon after select");
    a_mosi_stable_high: assert property (sclk |-> $stable(mosi))
        else $error("data changed while serial clock high");
    a_frame_bit_count: assert property ($rose(cs_n) |-> rises == 6'h20)
        else $error("frame without 32 clock rises");
    a_lowp_after_frame: assert property (
        $rose(O_LOW_POWER) |-> $past(cs_n, 3))
        else $error("low power entered inside a frame");
    a_wake_on_select: assert property (
        (O_LOW_POWER && $fell(cs_n)) |-> ##[0:8] !O_LOW_POWER)
        else $error("no wake after select");
    a_poll_follows_state: assert property (
        O_LP_POLL_EN == (O_LOW_POWER && I_CFG_POLL_EN))
        else $error("polling enable wrong");
    a_timer_follows_state: assert property (
        O_LP_TIMER_EN == (O_LOW_POWER && I_CFG_TIMER_EN))
        else $error("timer enable wrong");
    a_sel_one_hot: assert property ($onehot0(O_BUFFERED_ANALOG_OUTPUT_SEL))
        else $error("more than one analog source");
    a_sel_code_decode: assert property (O_BUFFERED_ANALOG_OUTPUT_SEL == exp_sel)
        else $error("analog source does not match code");
    a_wet_needs_source: assert property (
        O_BUFFERED_ANALOG_OUTPUT_WET_PULLUP |-> O_BUFFERED_ANALOG_OUTPUT_SEL != '0)
        else $error("pull-up current without a source");
    a_select_held_lowp: assert property (O_LOW_POWER |->
        $stable(O_BUFFERED_ANALOG_OUTPUT_CHAN) && $stable(O_BUFFERED_ANALOG_OUTPUT_WET_PULLUP))
        else $error("analog select changed in low power");

    c_lowp_entry: cover property ($rose(O_LOW_POWER));
    c_wet_on: cover property ($rose(O_BUFFERED_ANALOG_OUTPUT_WET_PULLUP));
    c_frame_end: cover property ($rose(cs_n));
endmodule
`default_nettype wire

// File: dv/lpa_test.sv
`timescale 1ns/100ps
`default_nettype none
module lpa_test;
    import lpa_pkg::*;
    logic              clk      = 1'b0;
    logic              rst_n    = 1'b0;
    logic [7:0]        wb_adr   = 8'h00;
    logic [31:0]       wb_dat   = 32'h0;
    logic [3:0]        wb_sel   = 4'h0;
    logic              wb_we    = 1'b0;
    logic              wb_cyc   = 1'b0;
    logic              wb_stb   = 1'b0;
    logic [N_GND-1:0]  gnd_sw   = 21'h15a5a5;
    logic [N_PRG-1:0]  prg_sw   = 12'ha5c;
    logic              fault    = 1'b0;
    logic              int_ev   = 1'b0;
    logic              poll_en  = 1'b0;
    logic              timer_en = 1'b0;
    logic [31:0]       wb_q;
    logic              wb_ack;
    logic              irq;
    logic [N_CHAN-1:0] buffered_analog_output_sel;
    logic [5:0]        buffered_analog_output_chan;
    logic              wet;
    logic              low_power;
    logic              lp_poll;
    logic              lp_timer;
    int                fails    = 0;
    int                checked  = 0;
    logic [5:0]        codes [9] = '{6'h00, 6'h01, 6'h15, 6'h16, 6'h21,
                                     6'h22, 6'h23, 6'h24, 6'h3f};

    lpa_link_if link();

    lpa_dev i_lpa_dev (.I_CORE_CLK(clk), .I_RSTN(rst_n), .LINK(link),
        .I_GND_SW(gnd_sw), .I_PRG_SW(prg_sw), .I_FAULT(fault),
        .I_INT_EVENT(int_ev), .I_CFG_POLL_EN(poll_en),
        .I_CFG_TIMER_EN(timer_en), .O_BUFFERED_ANALOG_OUTPUT_SEL(buffered_analog_output_sel),
        .O_BUFFERED_ANALOG_OUTPUT_CHAN(buffered_analog_output_chan), .O_BUFFERED_ANALOG_OUTPUT_WET_PULLUP(wet),
        .O_LOW_POWER(low_power), .O_LP_POLL_EN(lp_poll),
        .O_LP_TIMER_EN(lp_timer));

    lpa_host i_lpa_host (.I_CORE_CLK(clk), .I_RSTN(rst_n), .LINK(link),
        .I_WB_ADR(wb_adr), .I_WB_DAT(wb_dat), .I_WB_SEL(wb_sel),
        .I_WB_WE(wb_we), .I_WB_CYC(wb_cyc), .I_WB_STB(wb_stb),
        .O_WB_DAT(wb_q), .O_WB_ACK(wb_ack), .O_IRQ(irq));

    lpa_assertions i_lpa_assertions (.I_CORE_CLK(clk), .I_RSTN(rst_n),
        .cs_n(link.cs_n), .sclk(link.sclk), .mosi(link.mosi),
        .I_CFG_POLL_EN(poll_en), .I_CFG_TIMER_EN(timer_en),
        .O_BUFFERED_ANALOG_OUTPUT_SEL(buffered_analog_output_sel), .O_BUFFERED_ANALOG_OUTPUT_CHAN(buffered_analog_output_chan),
        .O_BUFFERED_ANALOG_OUTPUT_WET_PULLUP(wet), .O_LOW_POWER(low_power),
        .O_LP_POLL_EN(lp_poll), .O_LP_TIMER_EN(lp_timer));

    always #(CLK_NS / 2) clk = ~clk;

    function automatic logic [31:0] cmd(logic [6:0] a, logic w,
                                        logic [23:0] d);
        return {a, w, d};
    endfunction

    task automatic chk_w(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("Error %0t word %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_b(input logic got, input logic exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("Error %0t bit %b expected %b", $time, got, exp);
        end
    endtask

    // One classic Wishbone cycle; entered and left just after a clock edge.
    task automatic wb(input logic [7:0] a, input logic w,
                      input logic [31:0] d, output logic [31:0] q);
        int n;
        wb_adr <= a;
        wb_we  <= w;
        wb_dat <= d;
        wb_sel <= 4'hf;
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (wb_ack !== 1'b1);
        chk_b(n == 2, 1'b1);
        q = wb_q;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we  <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wait_idle();
        logic [31:0] s;
        int n;
        n = 0;
        do begin
            wb(WB_STAT, 1'b0, 32'h0, s);
            n++;
        end while (s[0] !== 1'b0 && n < 400);
        chk_b(s[0], 1'b0);
    endtask

    // Sends one frame and returns the word received during it.
    task automatic frame(input logic [31:0] c, output logic [31:0] r);
        wait_idle();
        wb(WB_CMD, 1'b1, c, r);
        wait_idle();
        wb(WB_RESP, 1'b0, 32'h0, r);
    endtask

    task automatic t_boot();
        logic [31:0] r;
        chk_b(|{buffered_analog_output_sel, buffered_analog_output_chan, wet, low_power}, 1'b0);
        wait_idle();
        wb(WB_RESP, 1'b0, 32'h0, r);
        chk_w(r, {8'h00, 2'b01, 1'b0, gnd_sw});
        frame(cmd(ADDR_SG_STAT, 1'b0, 24'h0), r);
        chk_w(r, {8'h00, 2'b00, 10'h000, prg_sw});
    endtask

    task automatic t_buffered_analog_output();
        logic [31:0]       r;
        logic [6:0]        v;
        logic [6:0]        prev;
        logic [6:0]        pp;
        logic [N_CHAN-1:0] e;
        prev = 7'h00;
        pp   = 7'h00;
        for (int i = 0; i < 9; i++) begin
            v = {i[0], codes[i]};
            e = '0;
            if (codes[i] >= 6'h01 && codes[i] <= 6'h23) begin
                e = 35'h1 << (codes[i] - 6'h01);
            end
            frame(cmd(ADDR_ASEL, 1'b1, {17'h0, v}), r);
            if (i > 0) chk_w(r, {10'h000, 15'h0, pp});
            chk_w({26'h0, buffered_analog_output_chan}, {26'h0, codes[i]});
            chk_b(buffered_analog_output_sel === e, 1'b1);
            chk_b(wet, i[0] && (e != '0));
            pp   = prev;
            prev = v;
        end
    endtask

    task automatic t_zero();
        logic [31:0] r;
        gnd_sw <= '1;
        prg_sw <= '1;
        frame(cmd(ADDR_ASEL, 1'b1, 24'h000005), r);
        frame(cmd(ADDR_SG_STAT, 1'b0, 24'h0), r);
        frame(cmd(ADDR_ASEL, 1'b1, 24'h000019), r);
        chk_w(r, {10'h000, 1'b0, 21'h1fffef});
        frame(cmd(ADDR_SP_STAT, 1'b0, 24'h0), r);
        frame(cmd(ADDR_ASEL, 1'b0, 24'h0), r);
        chk_w(r, {10'h000, 10'h000, 12'hff7});
        gnd_sw <= 21'h15a5a5;
        prg_sw <= 12'ha5c;
    endtask

    task automatic t_lowp();
        logic [31:0] r;
        poll_en  <= 1'b1;
        timer_en <= 1'b1;
        frame(cmd(ADDR_ASEL, 1'b1, 24'h000047), r);
        frame(cmd(ADDR_LPM_ENTRY, 1'b1, 24'h000100), r);
        frame(cmd(ADDR_LPM_ENTRY, 1'b0, 24'h0), r);
        chk_b(low_power, 1'b0);
        frame(cmd(ADDR_LPM_ENTRY, 1'b1, 24'h0), r);
        chk_w({29'h0, low_power, lp_poll, lp_timer}, 32'h7);
        frame(cmd(ADDR_ASEL, 1'b0, 24'h0), r);
        chk_w(r & 32'hff3fffff, {11'h000, 21'h15a5a5});
        chk_b(low_power, 1'b0);
        frame(cmd(ADDR_ASEL, 1'b0, 24'h0), r);
        chk_w(r, {10'h000, 22'h000047});
        poll_en  <= 1'b0;
        timer_en <= 1'b0;
    endtask

    task automatic t_flags();
        logic [31:0] r;
        logic [31:0] ra;
        wb(WB_ISR, 1'b1, 32'h1, r);
        wb(WB_IMR, 1'b1, 32'h0, r);
        wb(WB_ISR, 1'b0, 32'h0, r);
        chk_w(r, 32'h0);
        fault  <= 1'b1;
        int_ev <= 1'b1;
        @(posedge clk);
        int_ev <= 1'b0;
        frame(cmd(ADDR_SP_STAT, 1'b0, 24'h0), ra);
        wb(WB_ISR, 1'b0, 32'h0, r);
        chk_w(r, 32'h1);
        chk_b(irq, 1'b0);
        wb(WB_IMR, 1'b1, 32'h1, r);
        chk_b(irq, 1'b1);
        frame(cmd(ADDR_ASEL, 1'b0, 24'h0), r);
        chk_b(ra[22] ^ r[22], 1'b1);
        chk_w({1'b0, r[31:23], r[21:0]},
              {1'b0, 9'h001, 10'h000, 12'ha5c});
        wb(WB_ISR, 1'b1, 32'h1, r);
        chk_b(irq, 1'b0);
        wb(8'h20, 1'b0, 32'h0, r);
        chk_w(r, 32'h0);
        fault <= 1'b0;
    endtask

    task automatic wrap_up();
        $display("Checks %0d, mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        repeat (80000) @(posedge clk);
        fails++;
        $display("Error %0t watchdog expired", $time);
        wrap_up();
    end

    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_boot();
        t_buffered_analog_output();
        t_zero();
        t_lowp();
        t_flags();
        wrap_up();
    end
endmodule
`default_nettype wire
